// ===== core/ioc_cell.sv
// One programmable I/O cell: input capture, routed input paths and output stage.
// Assumes all pad and routing inputs are synchronous to i_mclk; clocks from the
// routing arrive as levels and their edges are detected here.
`timescale 1ns/1ns
module ioc_cell (
	input  wire  logic        i_mclk,
	input  wire  logic        i_rst,
	input  wire  logic        psel,
	input  wire  logic        penable,
	input  wire  logic        pwrite,
	input  wire  logic [11:0] paddr,
	input  wire  logic [31:0] pwdata,
	output logic       [31:0] prdata,
	output logic              pready,
	output logic              pslverr,
	input  wire  logic        i_pad_in,
	input  wire  logic        i_sys_clk,
	input  wire  logic        i_fast_edge_clock,
	input  wire  logic        i_clock_enable,
	input  wire  logic        i_local_set_reset,
	input  wire  logic        i_global_set_reset,
	input  wire  logic        i_out_data_a,
	input  wire  logic        i_out_data_b,
	input  wire  logic        i_out_enable,
	output logic              o_routed_input_a,
	output logic              o_routed_input_b,
	output logic              o_fast_clk_path,
	output logic              o_pad_out,
	output logic              o_pad_oe,
	output logic              o_pull_up,
	output logic              o_pull_down
);
	import ioc_pkg::*;

	ioc_in_cfg_t  in_cfg;
	ioc_ctl_cfg_t ctl_cfg;
	ioc_out_cfg_t out_cfg;
	logic         pad_q;
	logic [INPUT_DELAY_CYC-1:0] pad_dly;
	logic [INPUT_DELAY_CYC:0]   dly_chain;
	logic         in_clk_prev;
	logic         out_clk_prev;
	logic         zh_latch;
	logic         cap;
	logic         out_ff;
	logic         data_in;
	logic         in_clk;
	logic         in_edge;
	logic         out_clk;
	logic         out_edge;
	logic         ce_on;
	logic         lsr_on;
	logic         gsr_hit;
	logic         lsr_now;
	logic         off_d;
	logic         out_val;
	logic         drive_ok;
	logic         ts_on;
	logic         apb_hit;
	logic         addr_ok;

	// APB slave: one wait state, then pready for one cycle; write lands on that edge.
	assign addr_ok = (paddr == ADDR_IN_CFG) || (paddr == ADDR_CTL_CFG) ||
	                 (paddr == ADDR_OUT_CFG) || (paddr == ADDR_STATUS);
	assign apb_hit = psel && penable && pready;

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !addr_ok;
			prdata  <= 32'h0000_0000;
			if (psel && penable && !pready && !pwrite) begin
				unique case (paddr)
					ADDR_IN_CFG:  prdata <= {{(32-IN_CFG_W){1'b0}}, in_cfg};
					ADDR_CTL_CFG: prdata <= {{(32-CTL_CFG_W){1'b0}}, ctl_cfg};
					ADDR_OUT_CFG: prdata <= {{(32-OUT_CFG_W){1'b0}}, out_cfg};
					ADDR_STATUS:  prdata <= {27'h000_0000, o_pad_oe, pad_q, out_ff,
					                         zh_latch, cap};
					default:      prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			in_cfg  <= IN_CFG_RESET;
			ctl_cfg <= CTL_CFG_RESET;
			out_cfg <= OUT_CFG_RESET;
		end else if (apb_hit && pwrite) begin
			if (paddr == ADDR_IN_CFG)
				in_cfg <= pwdata[IN_CFG_W-1:0];
			if (paddr == ADDR_CTL_CFG)
				ctl_cfg <= pwdata[CTL_CFG_W-1:0];
			if (paddr == ADDR_OUT_CFG)
				out_cfg <= pwdata[OUT_CFG_W-1:0];
		end
	end

	// Pad sampling and the optional delay line on the general routing inputs.
	assign dly_chain = {pad_dly, pad_q};

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			pad_q   <= 1'b0;
			pad_dly <= '0;
		end else begin
			pad_q   <= i_pad_in;
			pad_dly <= dly_chain[INPUT_DELAY_CYC-1:0];
		end
	end

	assign data_in  = in_cfg.delay_en ? pad_dly[INPUT_DELAY_CYC-1] : pad_q;
	assign in_clk   = i_sys_clk ^ in_cfg.clk_invert;
	assign in_edge  = in_clk && !in_clk_prev;
	assign out_clk  = (out_cfg.out_clk_fast ? i_fast_edge_clock : i_sys_clk)
	                  ^ out_cfg.out_clk_invert;
	assign out_edge = out_clk && !out_clk_prev;

	// Control senses shared by the input and output registers.
	always_comb begin
		unique case (ctl_cfg.ce_mode)
			SEL_HIGH: ce_on = i_clock_enable;
			SEL_LOW:  ce_on = !i_clock_enable;
			default:  ce_on = 1'b1;
		endcase
		unique case (ctl_cfg.lsr_level)
			SEL_HIGH: lsr_on = i_local_set_reset;
			SEL_LOW:  lsr_on = !i_local_set_reset;
			default:  lsr_on = 1'b0;
		endcase
	end

	assign gsr_hit = i_global_set_reset && ctl_cfg.gsr_enable;
	// An edge-time set/reset obeys the priority choice; with enable first it waits for enable.
	assign lsr_now = lsr_on && (ctl_cfg.lsr_over_ce || ce_on);

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			in_clk_prev  <= 1'b0;
			out_clk_prev <= 1'b0;
		end else begin
			in_clk_prev  <= in_clk;
			out_clk_prev <= out_clk;
		end
	end

	// Fast capture latch, transparent while the fast edge clock is high.
	always_ff @(posedge i_mclk) begin
		if (i_rst)
			zh_latch <= 1'b0;
		else if (i_fast_edge_clock)
			zh_latch <= data_in;
	end

	// Input capture element.
	always_ff @(posedge i_mclk) begin
		if (i_rst)
			cap <= 1'b0;
		else if (gsr_hit)
			cap <= ctl_cfg.lsr_value;
		else if (lsr_on && ctl_cfg.lsr_async && in_cfg.cap_mode != CAP_BYPASS)
			cap <= ctl_cfg.lsr_value;
		else begin
			unique case (in_cfg.cap_mode)
				CAP_LATCH: begin
					if (in_clk && lsr_on)
						cap <= ctl_cfg.lsr_value;
					else if (in_clk)
						cap <= data_in;
				end
				CAP_FF: begin
					if (in_edge && lsr_now)
						cap <= ctl_cfg.lsr_value;
					else if (in_edge && ce_on)
						cap <= data_in;
				end
				CAP_ZERO_HOLD: begin
					if (in_edge && lsr_now)
						cap <= ctl_cfg.lsr_value;
					else if (in_edge && ce_on)
						cap <= zh_latch;
				end
				default: cap <= data_in;
			endcase
		end
	end

	// Routed input paths; a disabled path holds low.
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_routed_input_a <= 1'b0;
			o_routed_input_b <= 1'b0;
			o_fast_clk_path  <= 1'b0;
		end else begin
			o_routed_input_a <= in_cfg.path_en[0] && cap;
			o_routed_input_b <= in_cfg.path_en[1] && data_in;
			o_fast_clk_path  <= in_cfg.path_en[2] && pad_q;
		end
	end

	// Output flip-flop.
	always_comb begin
		unique case (out_cfg.ff_data_sel)
			OFF_SRC_A:   off_d = i_out_data_a;
			OFF_SRC_B:   off_d = i_out_data_b;
			OFF_SRC_ONE: off_d = 1'b1;
			default:     off_d = 1'b0;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst)
			out_ff <= 1'b0;
		else if (gsr_hit)
			out_ff <= ctl_cfg.lsr_value;
		else if (lsr_on && ctl_cfg.lsr_async)
			out_ff <= ctl_cfg.lsr_value;
		else if (out_edge && lsr_now)
			out_ff <= ctl_cfg.lsr_value;
		else if (out_edge && ce_on)
			out_ff <= off_d ^ out_cfg.ff_data_invert;
	end

	// Pad drive. Until configuration is done, or when unused, the pad floats with pull-up.
	assign out_val  = (out_cfg.source_ff ? out_ff : i_out_data_a)
	                  ^ out_cfg.out_invert;
	assign drive_ok = out_cfg.config_done && out_cfg.pad_used;
	assign ts_on    = i_out_enable ^ out_cfg.ts_active_low;

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_pad_out   <= 1'b0;
			o_pad_oe    <= 1'b0;
			o_pull_up   <= 1'b1;
			o_pull_down <= 1'b0;
		end else if (!drive_ok) begin
			o_pad_out   <= 1'b0;
			o_pad_oe    <= 1'b0;
			o_pull_up   <= 1'b1;
			o_pull_down <= 1'b0;
		end else begin
			// Open drain pulls low only; a high value releases the pad.
			o_pad_out   <= out_cfg.open_drain ? 1'b0 : out_val;
			o_pad_oe    <= out_cfg.open_drain ? !out_val : ts_on;
			o_pull_up   <= in_cfg.pull_sel == SEL_HIGH;
			o_pull_down <= in_cfg.pull_sel == SEL_LOW;
		end
	end

	chk_latch_follow_data: assert property (@(posedge i_mclk) disable iff (i_rst)
		in_cfg.cap_mode == CAP_LATCH && in_clk && !lsr_on && !gsr_hit
		|=> cap == $past(data_in))
		else $error("latch not transparent while clock high");

	chk_ff_hold_no_edge: assert property (@(posedge i_mclk) disable iff (i_rst)
		in_cfg.cap_mode == CAP_FF && !in_edge && !lsr_on && !gsr_hit
		|=> $stable(cap))
		else $error("flip-flop changed without clock edge");

	chk_ce_gates_capture: assert property (@(posedge i_mclk) disable iff (i_rst)
		in_cfg.cap_mode == CAP_FF && in_edge && !ce_on && !lsr_on && !gsr_hit
		|=> $stable(cap))
		else $error("capture happened with clock enable off");

	chk_lsr_priority: assert property (@(posedge i_mclk) disable iff (i_rst)
		out_edge && lsr_on && !ce_on && !ctl_cfg.lsr_over_ce && !ctl_cfg.lsr_async
		&& !gsr_hit |=> $stable(out_ff))
		else $error("set/reset overrode clock enable priority");

	chk_gsr_forces: assert property (@(posedge i_mclk) disable iff (i_rst)
		gsr_hit |=> cap == $past(ctl_cfg.lsr_value) && out_ff == $past(ctl_cfg.lsr_value))
		else $error("chip-wide set/reset not applied");

	chk_fast_undelayed: assert property (@(posedge i_mclk) disable iff (i_rst)
		in_cfg.path_en[2] ##1 in_cfg.path_en[2] |-> o_fast_clk_path == $past(i_pad_in, 2))
		else $error("fast path delayed or wrong");

	chk_open_drain_high: assert property (@(posedge i_mclk) disable iff (i_rst)
		drive_ok && out_cfg.open_drain |=> !o_pad_out)
		else $error("open drain drove a high level");

	chk_unused_float: assert property (@(posedge i_mclk) disable iff (i_rst)
		!drive_ok |=> !o_pad_oe && o_pull_up && !o_pull_down)
		else $error("unused pad not floating with pull-up");

	chk_zero_hold_src: assert property (@(posedge i_mclk) disable iff (i_rst)
		in_cfg.cap_mode == CAP_ZERO_HOLD && in_edge && ce_on && !lsr_on && !gsr_hit
		|=> cap == $past(zh_latch))
		else $error("zero-hold flip-flop not fed by fast latch");

	chk_bypass_pass: assert property (@(posedge i_mclk) disable iff (i_rst)
		in_cfg.cap_mode == CAP_BYPASS && !gsr_hit |=> cap == $past(data_in))
		else $error("bypass capture did not follow the pad");

	chk_route_a_gate: assert property (@(posedge i_mclk) disable iff (i_rst)
		!in_cfg.path_en[0] |=> !o_routed_input_a)
		else $error("disabled routed line a not held low");

	chk_delay_line_b: assert property (@(posedge i_mclk) disable iff (i_rst)
		in_cfg.delay_en && in_cfg.path_en[1]
		|=> o_routed_input_b == $past(pad_dly[INPUT_DELAY_CYC-1]))
		else $error("routed line b not taken from the delay line");

	chk_async_reset_out: assert property (@(posedge i_mclk) disable iff (i_rst)
		lsr_on && ctl_cfg.lsr_async && !gsr_hit |=> out_ff == $past(ctl_cfg.lsr_value))
		else $error("asynchronous set/reset missed the output register");

	chk_pull_select: assert property (@(posedge i_mclk) disable iff (i_rst)
		drive_ok |=> o_pull_down == $past(in_cfg.pull_sel == SEL_LOW))
		else $error("pull-down enable does not match the termination choice");

	chk_drive_source: assert property (@(posedge i_mclk) disable iff (i_rst)
		drive_ok && !out_cfg.open_drain |=> o_pad_out == $past(out_val))
		else $error("driven pad value not taken from the selected source");

	chk_apb_answer: assert property (@(posedge i_mclk) disable iff (i_rst)
		psel && !penable ##1 psel && penable |=> pready ##1 !pready)
		else $error("APB answer not one wait state");
endmodule : ioc_cell

// ===== core/ioc_pkg.sv
// Package for the I/O cell logic: register map, field positions and config layouts.
// Assumes one 50 MHz clock and an APB slave with 32-bit data.
package ioc_pkg;
	localparam int          CLK_PERIOD_NS    = 20;
	localparam int          INPUT_DELAY_NS   = 20;
	localparam int          INPUT_DELAY_CYC  = (INPUT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [11:0] ADDR_IN_CFG      = 12'h000;
	localparam logic [11:0] ADDR_CTL_CFG     = 12'h004;
	localparam logic [11:0] ADDR_OUT_CFG     = 12'h008;
	localparam logic [11:0] ADDR_STATUS      = 12'h00C;
	localparam logic [8:0]  IN_CFG_RESET     = 9'h000;
	localparam logic [7:0]  CTL_CFG_RESET    = 8'h00;
	localparam logic [10:0] OUT_CFG_RESET    = 11'h000;
	localparam int          IN_CFG_W         = 9;
	localparam int          CTL_CFG_W        = 8;
	localparam int          OUT_CFG_W        = 11;
	// Capture modes.
	localparam logic [1:0]  CAP_BYPASS       = 2'h0;
	localparam logic [1:0]  CAP_LATCH        = 2'h1;
	localparam logic [1:0]  CAP_FF           = 2'h2;
	localparam logic [1:0]  CAP_ZERO_HOLD    = 2'h3;
	// Three-way selects for clock enable, set/reset level and weak termination.
	localparam logic [1:0]  SEL_OFF          = 2'h0;
	localparam logic [1:0]  SEL_HIGH         = 2'h1;
	localparam logic [1:0]  SEL_LOW          = 2'h2;
	// Output flip-flop data source.
	localparam logic [1:0]  OFF_SRC_A        = 2'h0;
	localparam logic [1:0]  OFF_SRC_B        = 2'h1;
	localparam logic [1:0]  OFF_SRC_ONE      = 2'h2;
	localparam logic [1:0]  OFF_SRC_ZERO     = 2'h3;

	typedef struct packed {
		logic [2:0] path_en;      // [2] fast clock path, [1] line b, [0] line a
		logic [1:0] pull_sel;     // off, pull-up, pull-down
		logic       delay_en;
		logic       clk_invert;
		logic [1:0] cap_mode;
	} ioc_in_cfg_t;

	typedef struct packed {
		logic       lsr_value;    // 1 sets, 0 resets
		logic       gsr_enable;
		logic       lsr_over_ce;
		logic       lsr_async;
		logic [1:0] lsr_level;
		logic [1:0] ce_mode;
	} ioc_ctl_cfg_t;

	typedef struct packed {
		logic       config_done;
		logic       pad_used;
		logic       out_clk_invert;
		logic       out_clk_fast;
		logic       ts_active_low;
		logic       out_invert;
		logic       ff_data_invert;
		logic [1:0] ff_data_sel;
		logic       source_ff;
		logic       open_drain;
	} ioc_out_cfg_t;
endpackage : ioc_pkg

// ===== dv/ioc_pad_model.sv
// Pad-side partner: an external driver and the pad's weak termination.
// Assumes the cell's pad drive and pull enables are registered on i_mclk.
`timescale 1ns/1ns
module ioc_pad_model (
	input  wire logic i_mclk,
	input  wire logic i_drive,
	input  wire logic i_level,
	input  wire logic i_pad_out,
	input  wire logic i_pad_oe,
	input  wire logic i_pull_up,
	input  wire logic i_pull_down,
	output logic      o_pad
);
	logic wander = 1'b0;

	// A pad nobody drives or terminates has no level, so it must not look stable.
	always @(posedge i_mclk) begin
		wander <= ~wander;
	end

	always_comb begin
		if (i_pad_oe)
			o_pad = i_pad_out;
		else if (i_drive)
			o_pad = i_level;
		else if (i_pull_up)
			o_pad = 1'b1;
		else if (i_pull_down)
			o_pad = 1'b0;
		else
			o_pad = wander;
	end
endmodule : ioc_pad_model

// ===== dv/test_io_cell_input_register_control.sv
// Self-checking bench for the I/O cell: APB set-up, pad stimulus and port checks.
// Assumes all stimulus moves by non-blocking assignment right after i_mclk rises.
`timescale 1ns/1ns
module test_io_cell_input_register_control;
	import ioc_pkg::*;
	logic        i_mclk = 1'b0;
	logic        i_rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, pad, sys, fclk, ce, local_set_reset, global_set_reset, oa, ob, oen, lvl;
	logic        ra, rb, rf, pout, poe, pu, pd;
	logic [31:0] q;
	logic        e;
	int          failures = 0;
	int          samples_checked = 0;
	int          cycles = 0;

	initial {sys, fclk, ce, global_set_reset, oa, ob, oen, lvl} = 8'h00;
	initial local_set_reset = 1'b1;
	always #10 i_mclk = ~i_mclk;

	ioc_cell ioc_cell_inst (.i_mclk(i_mclk), .i_rst(i_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .i_pad_in(pad), .i_sys_clk(sys), .i_fast_edge_clock(fclk),
		.i_clock_enable(ce), .i_local_set_reset(local_set_reset), .i_global_set_reset(global_set_reset),
		.i_out_data_a(oa), .i_out_data_b(ob), .i_out_enable(oen),
		.o_routed_input_a(ra), .o_routed_input_b(rb), .o_fast_clk_path(rf),
		.o_pad_out(pout), .o_pad_oe(poe), .o_pull_up(pu), .o_pull_down(pd));
	ioc_pad_model ioc_pad_model_inst (.i_mclk(i_mclk), .i_drive(1'b1), .i_level(lvl),
		.i_pad_out(pout), .i_pad_oe(poe), .i_pull_up(pu), .i_pull_down(pd), .o_pad(pad));

	task automatic complete_run();
		if (failures == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run

	task automatic cyc(input int n);
		repeat (n) @(posedge i_mclk);
	endtask : cyc

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Values are taken at the edge that sees pready, before that edge's updates land.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_mclk);
		penable <= 1'b1;
		do begin
			@(posedge i_mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			failures++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		cyc(3);
	endtask : wr

	task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(what, q, exp);
		check("read error", {31'h0, e}, 32'h0);
	endtask : rd

	task automatic pulse_sys();
		sys <= 1'b1;
		cyc(3);
		sys <= 1'b0;
		cyc(3);
	endtask : pulse_sys

	always @(posedge i_mclk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			failures++;
			complete_run();
		end
	end

	initial begin
		cyc(8);
		i_rst <= 1'b0;
		cyc(2);
		check("pull_up", {31'h0, pu}, 32'h1);
		check("pad_oe", {31'h0, poe}, 32'h0);
		rd("in_cfg", ADDR_IN_CFG, 32'h0);
		rd("ctl_cfg", ADDR_CTL_CFG, 32'h0);
		rd("out_cfg", ADDR_OUT_CFG, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		check("unmapped error", {31'h0, e}, 32'h1);
		wr(ADDR_IN_CFG, 32'hFFFFFFFF);
		rd("in_cfg wide", ADDR_IN_CFG, 32'h1FF);
		wr(ADDR_IN_CFG, 32'h1C8);
		lvl <= 1'b1;
		cyc(3);
		check("fast path", {31'h0, rf}, 32'h1);
		check("delayed b", {31'h0, rb}, 32'h0);
		cyc(1);
		check("delayed b", {31'h0, rb}, 32'h1);
		cyc(3);
		check("bypass a", {31'h0, ra}, 32'h1);
		wr(ADDR_IN_CFG, 32'h1C0);
		lvl <= 1'b0;
		cyc(3);
		check("undelayed b", {31'h0, rb}, 32'h0);
		// Flip-flop mode with clock enable active high, then active low.
		wr(ADDR_CTL_CFG, 32'h01);
		wr(ADDR_IN_CFG, 32'h42);
		lvl <= 1'b1;
		pulse_sys();
		check("ce off", {31'h0, ra}, 32'h0);
		ce <= 1'b1;
		pulse_sys();
		check("ce on", {31'h0, ra}, 32'h1);
		wr(ADDR_CTL_CFG, 32'h02);
		lvl <= 1'b0;
		pulse_sys();
		check("ce low off", {31'h0, ra}, 32'h1);
		ce <= 1'b0;
		pulse_sys();
		check("ce low on", {31'h0, ra}, 32'h0);
		// Inverted capture clock takes data on the falling routed edge.
		wr(ADDR_CTL_CFG, 32'h00);
		wr(ADDR_IN_CFG, 32'h46);
		lvl <= 1'b1;
		sys <= 1'b1;
		cyc(3);
		check("inv rise", {31'h0, ra}, 32'h0);
		sys <= 1'b0;
		cyc(3);
		check("inv fall", {31'h0, ra}, 32'h1);
		wr(ADDR_IN_CFG, 32'h41);
		lvl <= 1'b0;
		cyc(3);
		check("latch hold", {31'h0, ra}, 32'h1);
		sys <= 1'b1;
		cyc(4);
		check("latch open", {31'h0, ra}, 32'h0);
		lvl <= 1'b1;
		cyc(4);
		check("latch follow", {31'h0, ra}, 32'h1);
		sys <= 1'b0;
		lvl <= 1'b0;
		cyc(4);
		check("latch shut", {31'h0, ra}, 32'h1);
		wr(ADDR_IN_CFG, 32'h43);
		fclk <= 1'b1;
		cyc(2);
		fclk <= 1'b0;
		lvl <= 1'b1;
		cyc(2);
		pulse_sys();
		check("zero hold", {31'h0, ra}, 32'h0);
		// Local set/reset: asynchronous first, then synchronous with both priorities.
		wr(ADDR_IN_CFG, 32'h42);
		wr(ADDR_CTL_CFG, 32'h99);
		local_set_reset <= 1'b0;
		cyc(3);
		check("async set", {31'h0, ra}, 32'h1);
		local_set_reset <= 1'b1;
		ce <= 1'b1;
		lvl <= 1'b0;
		wr(ADDR_CTL_CFG, 32'hA9);
		pulse_sys();
		local_set_reset <= 1'b0;
		cyc(3);
		check("sync waits", {31'h0, ra}, 32'h0);
		// With enable off, set/reset first acts; enable first holds the register.
		ce <= 1'b0;
		pulse_sys();
		check("lsr wins", {31'h0, ra}, 32'h1);
		wr(ADDR_CTL_CFG, 32'h09);
		pulse_sys();
		check("ce wins", {31'h0, ra}, 32'h1);
		local_set_reset <= 1'b1;
		lvl <= 1'b1;
		pulse_sys();
		wr(ADDR_CTL_CFG, 32'h00);
		global_set_reset <= 1'b1;
		cyc(3);
		check("gsr off", {31'h0, ra}, 32'h1);
		wr(ADDR_CTL_CFG, 32'h40);
		check("gsr on", {31'h0, ra}, 32'h0);
		global_set_reset <= 1'b0;
		wr(ADDR_CTL_CFG, 32'h00);
		// Output stage.
		oa <= 1'b1;
		oen <= 1'b1;
		wr(ADDR_OUT_CFG, 32'h400);
		check("unused oe", {31'h0, poe}, 32'h0);
		check("unused pull", {31'h0, pu}, 32'h1);
		wr(ADDR_OUT_CFG, 32'h600);
		check("route out", {30'h0, poe, pout}, 32'h3);
		wr(ADDR_OUT_CFG, 32'h620);
		check("out invert", {30'h0, poe, pout}, 32'h2);
		wr(ADDR_OUT_CFG, 32'h640);
		check("oe low", {31'h0, poe}, 32'h0);
		wr(ADDR_OUT_CFG, 32'h601);
		check("drain one", {30'h0, poe, pout}, 32'h0);
		oa <= 1'b0;
		cyc(3);
		check("drain zero", {30'h0, poe, pout}, 32'h2);
		wr(ADDR_OUT_CFG, 32'h60A);
		pulse_sys();
		check("ff one", {30'h0, poe, pout}, 32'h3);
		wr(ADDR_OUT_CFG, 32'h61A);
		pulse_sys();
		check("ff invert", {31'h0, pout}, 32'h0);
		ob <= 1'b1;
		wr(ADDR_OUT_CFG, 32'h606);
		pulse_sys();
		check("ff from b", {31'h0, pout}, 32'h1);
		ob <= 1'b0;
		wr(ADDR_OUT_CFG, 32'h686);
		fclk <= 1'b1;
		cyc(3);
		fclk <= 1'b0;
		cyc(3);
		check("ff fast clock", {31'h0, pout}, 32'h0);
		wr(ADDR_IN_CFG, 32'h62);
		check("pull down", {30'h0, pu, pd}, 32'h1);
		complete_run();
	end
endmodule : test_io_cell_input_register_control
